// >>> core/psi_core.sv
`timescale 1ns/1ns
// Function
// [R1] scanner image: control, target, parameter fields
// [R2] drive image: status, speed, position, reply
// [R3] no parameter channel shrinks images to eight
// [R4] reached set on commanded target arrival
// [R5] reached cleared by move, manual, invalid, turning
// [R6] readjusted shaft back in window sets reached
// [R7] drag error on excess following error
// [R8] jog key bits follow key inputs
// [R9] power bit while supply inside corridor
// [R10] abort bit on release loss or combination
// [R11] running bit follows shaft rotation
// [R12] overtemperature with five degree hysteresis
// [R13] loop bit set at reset and wrong-way runs
// [R14] fatal error sticky, blocks all runs
// [R15] block bit on overload abort
// [R16] displacement bit when turned at standstill
// [R17] bad target outside limits or loop range
// [R18] missing power at run start or during run
// [R19] missing power cleared by good start, acknowledge
// [R20] acknowledge on rising edge of control bit
// [R21] range limit bits for both limits
// [R22] status copied whole into image each cycle
module psi_core (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // cyclic images
    input wire psi_pkg::psi_out_img_s out_img,
    output psi_pkg::psi_in_img_s in_img,
    output logic [4:0] img_len,
    // motion engine and sensors
    input wire psi_pkg::psi_mot_s mot,
    input wire logic key_rev,
    input wire logic key_fwd,
    input wire logic [15:0] supply_mv,
    input wire logic [15:0] temp_c,
    // commands toward the motion engine
    output psi_pkg::psi_out_img_s cmd,
    output logic run_permit
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] abs_diff(input logic [31:0] a, input logic [31:0] b);
        logic [31:0] d;
        d = a - b;
        abs_diff = d[31] ? (32'h0 - d) : d;
    endfunction

    function automatic logic outside(input logic [31:0] v, input logic [31:0] hi,
                                     input logic [31:0] lo);
        outside = ($signed(v) > $signed(hi)) || ($signed(v) < $signed(lo));
    endfunction

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [2:0] ctrl;
    logic [31:0] pos_window;
    logic [31:0] drag_limit;
    logic [15:0] umot_min;
    logic [15:0] temp_limit;
    logic [31:0] reply_id;
    logic [31:0] reply_val;
    logic [31:0] lim_max;
    logic [31:0] lim_min;
    logic [15:0] status;
    logic [31:0] target_q;
    logic fin_ok;
    logic ack_prev;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    wire logic wr = psel && penable && pwrite;
    wire logic hit_rw = (paddr == psi_pkg::A_CTRL) || (paddr == psi_pkg::A_POS_WINDOW)
                        || (paddr == psi_pkg::A_DRAG_LIMIT) || (paddr == psi_pkg::A_UMOT_MIN)
                        || (paddr == psi_pkg::A_TEMP_LIMIT) || (paddr == psi_pkg::A_REPLY_ID)
                        || (paddr == psi_pkg::A_REPLY_VAL) || (paddr == psi_pkg::A_LIM_MAX)
                        || (paddr == psi_pkg::A_LIM_MIN);
    wire logic hit = hit_rw || (paddr == psi_pkg::A_STATUS);
    wire logic [31:0] bmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    // sixteen-bit registers keep only the low lanes of a merged word
    wire logic [31:0] umot_new = (umot_min & ~bmask[15:0]) | (pwdata[15:0] & bmask[15:0]);
    wire logic [31:0] temp_new = (temp_limit & ~bmask[15:0]) | (pwdata[15:0] & bmask[15:0]);

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [31:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction

    // zero wait states; unmapped addresses answer with an error and zero data
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;

    always_comb begin
        case (paddr)
            psi_pkg::A_CTRL: prdata = {29'h0, ctrl};
            psi_pkg::A_POS_WINDOW: prdata = pos_window;
            psi_pkg::A_DRAG_LIMIT: prdata = drag_limit;
            psi_pkg::A_UMOT_MIN: prdata = {16'h0, umot_min};
            psi_pkg::A_TEMP_LIMIT: prdata = {16'h0, temp_limit};
            psi_pkg::A_STATUS: prdata = {16'h0, status};
            psi_pkg::A_REPLY_ID: prdata = reply_id;
            psi_pkg::A_REPLY_VAL: prdata = reply_val;
            psi_pkg::A_LIM_MAX: prdata = lim_max;
            psi_pkg::A_LIM_MIN: prdata = lim_min;
            default: prdata = 32'h0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= psi_pkg::CTRL_RST;
            pos_window <= psi_pkg::POS_WINDOW_RST;
            drag_limit <= psi_pkg::DRAG_LIMIT_RST;
            umot_min <= psi_pkg::UMOT_MIN_RST;
            temp_limit <= psi_pkg::TEMP_LIMIT_RST;
            reply_id <= 32'h0;
            reply_val <= 32'h0;
            lim_max <= psi_pkg::LIM_MAX_RST;
            lim_min <= psi_pkg::LIM_MIN_RST;
        end else if (wr) begin
            case (paddr)
                psi_pkg::A_CTRL: ctrl <= pstrb[0] ? pwdata[2:0] : ctrl;
                psi_pkg::A_POS_WINDOW: pos_window <= merge(pos_window, pwdata, bmask);
                psi_pkg::A_DRAG_LIMIT: drag_limit <= merge(drag_limit, pwdata, bmask);
                psi_pkg::A_UMOT_MIN: umot_min <= umot_new[15:0];
                psi_pkg::A_TEMP_LIMIT: temp_limit <= temp_new[15:0];
                psi_pkg::A_REPLY_ID: reply_id <= merge(reply_id, pwdata, bmask);
                psi_pkg::A_REPLY_VAL: reply_val <= merge(reply_val, pwdata, bmask);
                psi_pkg::A_LIM_MAX: lim_max <= merge(lim_max, pwdata, bmask);
                psi_pkg::A_LIM_MIN: lim_min <= merge(lim_min, pwdata, bmask);
                default: ctrl <= ctrl;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // event decode
    // ----------------------------------------------------------------
    wire logic param_en = ctrl[psi_pkg::C_PARAM_EN];
    wire logic ack = out_img.control[psi_pkg::ACK_BIT] && !ack_prev; // see [R20]
    // a run is refused outright while the fatal bit stands
    wire logic run_go = mot.run_start && !status[psi_pkg::S_FATAL]; // see [R14]
    wire logic [31:0] pos_err = abs_diff(target_q, mot.actual_pos);
    wire logic [31:0] new_err = abs_diff(out_img.target, mot.actual_pos);
    wire logic supply_ok = (supply_mv > umot_min) && (supply_mv < psi_pkg::UMOT_MAX_MV);
    wire logic tgt_bad = mot.target_take && outside(out_img.target, lim_max, lim_min);
    // a run command ends the standstill, so it must not re-flag displacement
    wire logic turned = fin_ok && !mot.running && !run_go && (pos_err > pos_window);
    wire logic reached = mot.target_reached && !mot.run_manual;
    wire logic against = mot.run_fwd != ctrl[psi_pkg::C_LOOP_FWD];
    wire logic clr_common = run_go || ack;
    wire logic [15:0] temp_low = (temp_limit > psi_pkg::TEMP_HYST) ?
                                 (temp_limit - psi_pkg::TEMP_HYST) : 16'h0;

    logic [15:0] set_v;
    logic [15:0] clr_v;
    logic [15:0] next_status;

    always_comb begin
        set_v = 16'h0;
        clr_v = 16'h0;
        set_v[psi_pkg::S_REACHED] = reached // see [R4]
            || (status[psi_pkg::S_DISPLACED] && ctrl[psi_pkg::C_READJUST]
                && !mot.running && (pos_err <= pos_window)); // see [R6]
        clr_v[psi_pkg::S_REACHED] = (mot.target_take && (new_err > pos_window))
            || (run_go && mot.run_manual) || tgt_bad || turned; // see [R5]
        set_v[psi_pkg::S_DRAG] = mot.running && !mot.braking
            && (mot.follow_err > drag_limit); // see [R7]
        clr_v[psi_pkg::S_DRAG] = clr_common; // see [R7]
        set_v[psi_pkg::S_ABORT] = mot.abort_release || mot.abort_combo; // see [R10]
        clr_v[psi_pkg::S_ABORT] = clr_common; // see [R10]
        set_v[psi_pkg::S_OVERTEMP] = temp_c > temp_limit; // see [R12]
        clr_v[psi_pkg::S_OVERTEMP] = temp_c <= temp_low; // see [R12]
        set_v[psi_pkg::S_LOOP] = run_go && (against || mot.loop_len_zero); // see [R13]
        clr_v[psi_pkg::S_LOOP] = reached && !against; // see [R13]
        set_v[psi_pkg::S_FATAL] = mot.calc_fault; // see [R14]
        set_v[psi_pkg::S_BLOCK] = mot.abort_block; // see [R15]
        clr_v[psi_pkg::S_BLOCK] = clr_common; // see [R15]
        set_v[psi_pkg::S_DISPLACED] = turned; // see [R16]
        clr_v[psi_pkg::S_DISPLACED] = clr_common; // see [R16]
        set_v[psi_pkg::S_BAD_TARGET] = tgt_bad || mot.loop_violation; // see [R17]
        clr_v[psi_pkg::S_BAD_TARGET] = clr_common; // see [R17]
        set_v[psi_pkg::S_NO_POWER] = (run_go || mot.running) && !supply_ok; // see [R18]
        clr_v[psi_pkg::S_NO_POWER] = (run_go && supply_ok) || ack; // see [R19]
        // a limit held right at the edge after a manual run stays flagged
        set_v[psi_pkg::S_LIM_POS] = mot.lim_hit_pos
            || ($signed(mot.actual_pos) > $signed(lim_max)); // see [R21]
        clr_v[psi_pkg::S_LIM_POS] = $signed(mot.actual_pos) < $signed(lim_max);
        set_v[psi_pkg::S_LIM_NEG] = mot.lim_hit_neg
            || ($signed(mot.actual_pos) < $signed(lim_min)); // see [R21]
        clr_v[psi_pkg::S_LIM_NEG] = $signed(mot.actual_pos) > $signed(lim_min);
        // set wins over clear so an event in the clearing cycle survives
        next_status = set_v | (status & ~clr_v);
        next_status[psi_pkg::S_KEY_REV] = key_rev; // see [R8]
        next_status[psi_pkg::S_KEY_FWD] = key_fwd; // see [R8]
        next_status[psi_pkg::S_POWER] = supply_ok; // see [R9]
        next_status[psi_pkg::S_RUNNING] = mot.running; // see [R11]
    end

    // ----------------------------------------------------------------
    // status, image and command flops
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= psi_pkg::STATUS_RST; // see [R13]
            target_q <= 32'h0;
            fin_ok <= 1'b0;
            ack_prev <= 1'b0;
        end else begin
            status <= next_status;
            ack_prev <= out_img.control[psi_pkg::ACK_BIT];
            target_q <= (mot.target_take && !tgt_bad) ? out_img.target : target_q;
            fin_ok <= reached || (fin_ok && !run_go);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_img <= '0;
            cmd <= '0;
        end else begin
            in_img.status <= status; // see [R22]
            in_img.actual_speed <= mot.speed; // see [R2]
            in_img.actual_pos <= mot.actual_pos; // see [R2]
            in_img.param_identifier <= param_en ? reply_id[15:0] : 16'h0; // see [R3]
            in_img.param_index <= param_en ? reply_id[31:16] : 16'h0;
            in_img.param_value <= param_en ? reply_val : 32'h0;
            cmd.control <= out_img.control; // see [R1]
            cmd.unused <= 16'h0;
            cmd.target <= out_img.target; // see [R1]
            // parameter bytes beyond the short image are ignored
            cmd.param_identifier <= param_en ? out_img.param_identifier : 16'h0; // see [R3]
            cmd.param_index <= param_en ? out_img.param_index : 16'h0;
            cmd.param_value <= param_en ? out_img.param_value : 32'h0;
        end
    end

    assign img_len = param_en ? psi_pkg::IMG_FULL : psi_pkg::IMG_SHORT; // see [R3]
    assign run_permit = !status[psi_pkg::S_FATAL]; // see [R14]

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_ack_edge;
        !out_img.control[psi_pkg::ACK_BIT] ##1 out_img.control[psi_pkg::ACK_BIT];
    endsequence

    property p_fatal_sticky;
        status[psi_pkg::S_FATAL] |=> status[psi_pkg::S_FATAL];
    endproperty
    a_fatal_sticky: assert property (p_fatal_sticky) else $error("fatal bit dropped"); // see [R14]

    property p_permit;
        status[psi_pkg::S_FATAL] |-> !run_permit;
    endproperty
    a_permit: assert property (p_permit) else $error("run permitted with fatal bit"); // see [R14]

    property p_ack_clears_drag;
        s_ack_edge ##0 !(mot.running && !mot.braking && mot.follow_err > drag_limit)
            |=> !status[psi_pkg::S_DRAG];
    endproperty
    a_ack_clears_drag: assert property (p_ack_clears_drag) else $error("ack failed"); // see [R20]

    property p_keys;
        ##1 (status[psi_pkg::S_KEY_FWD] == $past(key_fwd))
            && (status[psi_pkg::S_KEY_REV] == $past(key_rev));
    endproperty
    a_keys: assert property (p_keys) else $error("jog key bits wrong"); // see [R8]

    property p_power;
        ##1 status[psi_pkg::S_POWER] == ($past(supply_mv) < psi_pkg::UMOT_MAX_MV
            && $past(supply_mv) > $past(umot_min));
    endproperty
    a_power: assert property (p_power) else $error("power bit wrong"); // see [R9]

    property p_overtemp_hold;
        status[psi_pkg::S_OVERTEMP] && temp_c > temp_low |=> status[psi_pkg::S_OVERTEMP];
    endproperty
    a_overtemp_hold: assert property (p_overtemp_hold) else $error("hysteresis lost"); // see [R12]

    property p_image;
        $past(presetn) |-> in_img.status == $past(status);
    endproperty
    a_image: assert property (p_image) else $error("status image torn"); // see [R22]

    property p_len;
        !param_en |-> img_len == psi_pkg::IMG_SHORT ##1 in_img.param_value == 32'h0;
    endproperty
    a_len: assert property (p_len) else $error("short image wrong"); // see [R3]

    property p_reached;
        reached |=> status[psi_pkg::S_REACHED] ##1 in_img.status[psi_pkg::S_REACHED];
    endproperty
    a_reached: assert property (p_reached) else $error("reached not flagged"); // see [R4]

    property p_block;
        mot.abort_block |=> status[psi_pkg::S_BLOCK];
    endproperty
    a_block: assert property (p_block) else $error("block bit missing"); // see [R15]
endmodule // psi_core

// >>> include/psi_pkg.sv
package psi_pkg;
    // ----------------------------------------------------------------
    // register map (word aligned byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_POS_WINDOW = 8'h04;
    localparam logic [7:0] A_DRAG_LIMIT = 8'h08;
    localparam logic [7:0] A_UMOT_MIN = 8'h0c;
    localparam logic [7:0] A_TEMP_LIMIT = 8'h10;
    localparam logic [7:0] A_STATUS = 8'h14;
    localparam logic [7:0] A_REPLY_ID = 8'h18;
    localparam logic [7:0] A_REPLY_VAL = 8'h1c;
    localparam logic [7:0] A_LIM_MAX = 8'h20;
    localparam logic [7:0] A_LIM_MIN = 8'h24;
    // control register fields and reset values
    localparam int C_PARAM_EN = 0;
    localparam int C_READJUST = 1;
    localparam int C_LOOP_FWD = 2;
    localparam logic [2:0] CTRL_RST = 3'h1;
    localparam logic [31:0] POS_WINDOW_RST = 32'h0000000a;
    localparam logic [31:0] DRAG_LIMIT_RST = 32'h00000064;
    localparam logic [15:0] UMOT_MIN_RST = 16'h4e20;
    localparam logic [15:0] TEMP_LIMIT_RST = 16'h0050;
    localparam logic [31:0] LIM_MAX_RST = 32'h7fffffff;
    localparam logic [31:0] LIM_MIN_RST = 32'h80000001;
    // ----------------------------------------------------------------
    // analog thresholds: supply in millivolts, temperature in degC
    // ----------------------------------------------------------------
    localparam logic [15:0] UMOT_MAX_MV = 16'h7530;
    localparam logic [15:0] TEMP_HYST = 16'h0005;
    // ----------------------------------------------------------------
    // status word bit positions and reset value
    // ----------------------------------------------------------------
    localparam int S_REACHED = 0;
    localparam int S_DRAG = 1;
    localparam int S_KEY_REV = 2;
    localparam int S_KEY_FWD = 3;
    localparam int S_POWER = 4;
    localparam int S_ABORT = 5;
    localparam int S_RUNNING = 6;
    localparam int S_OVERTEMP = 7;
    localparam int S_LOOP = 8;
    localparam int S_FATAL = 9;
    localparam int S_BLOCK = 10;
    localparam int S_DISPLACED = 11;
    localparam int S_BAD_TARGET = 12;
    localparam int S_NO_POWER = 13;
    localparam int S_LIM_POS = 14;
    localparam int S_LIM_NEG = 15;
    localparam logic [15:0] STATUS_RST = 16'h0100;
    localparam int ACK_BIT = 14;
    // image lengths in bytes
    localparam logic [4:0] IMG_FULL = 5'h10;
    localparam logic [4:0] IMG_SHORT = 5'h08;
    // ----------------------------------------------------------------
    // carriers; byte 0 of each image sits in the low bits
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [31:0] param_value;
        logic [15:0] param_index;
        logic [15:0] param_identifier;
        logic [31:0] target;
        logic [15:0] unused;
        logic [15:0] control;
    } psi_out_img_s;
    typedef struct packed {
        logic [31:0] param_value;
        logic [15:0] param_index;
        logic [15:0] param_identifier;
        logic [31:0] actual_pos;
        logic [15:0] actual_speed;
        logic [15:0] status;
    } psi_in_img_s;
    typedef struct packed {
        logic run_start;
        logic run_manual;
        logic run_fwd;
        logic loop_len_zero;
        logic target_take;
        logic target_reached;
        logic loop_violation;
        logic running;
        logic braking;
        logic abort_release;
        logic abort_combo;
        logic abort_block;
        logic calc_fault;
        logic lim_hit_pos;
        logic lim_hit_neg;
        logic [15:0] speed;
        logic [31:0] actual_pos;
        logic [31:0] follow_err;
    } psi_mot_s;
endpackage

// >>> verification/psi_scanner_model.sv
`timescale 1ns/1ns
module psi_scanner_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // application side of the scanner
    input wire logic [15:0] ctl,
    input wire logic [31:0] tgt,
    input wire logic [63:0] param,
    // assembly toward the drive
    input wire logic [4:0] img_len,
    output psi_pkg::psi_out_img_s out_img
);
    // ----------------------------------------------------------------
    // cyclic refresh
    // ----------------------------------------------------------------
    // the image changes only at a cycle boundary, never half-written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_img <= '0;
        end else begin
            out_img.control <= ctl;
            out_img.unused <= ~out_img.unused;
            out_img.target <= tgt;
            // a short image carries no parameter words, so the lanes hold junk
            if (img_len == psi_pkg::IMG_FULL) begin
                {out_img.param_value, out_img.param_index, out_img.param_identifier} <= param;
            end else begin
                {out_img.param_value, out_img.param_index, out_img.param_identifier} <= ~param;
            end
        end
    end
endmodule // psi_scanner_model

// >>> verification/psi_core_tb.sv
`timescale 1ns/1ns
module psi_core_tb;
    localparam int EV_TOP = $bits(psi_pkg::psi_mot_s) - 1;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [3:0] pstrb = 4'hf;
    logic pready, pslverr, e, run_permit, key_rev = 1'b0, key_fwd = 1'b0;
    logic [15:0] supply_mv = 16'h0, temp_c = 16'h0, ctl = 16'h0;
    logic [31:0] tgt = 32'h0;
    logic [63:0] param = 64'h0;
    logic [4:0] img_len;
    psi_pkg::psi_out_img_s out_img, cmd;
    psi_pkg::psi_in_img_s in_img;
    psi_pkg::psi_mot_s mot = '0;
    int num_errors = 0, samples_checked = 0;
    always #5 pclk = ~pclk;
    psi_scanner_model scanner (.pclk(pclk), .presetn(presetn), .ctl(ctl), .tgt(tgt),
        .param(param), .img_len(img_len), .out_img(out_img));
    psi_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .out_img(out_img), .in_img(in_img),
        .img_len(img_len), .mot(mot), .key_rev(key_rev), .key_fwd(key_fwd),
        .supply_mv(supply_mv), .temp_c(temp_c), .cmd(cmd), .run_permit(run_permit));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        samples_checked++;
        if (g !== x) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, x, g);
        end
    endtask
    task sb(input int b, input logic x);
        samples_checked++;
        if (in_img.status[b] !== x) begin
            num_errors++;
            $display("Error status bit %0d expected %b seen %b", b, x, in_img.status[b]);
        end
    endtask
    // one idle edge first, so a release and the next setup never share a step
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task pulse(input int k);
        mot[k] <= 1'b1;
        tick(1);
        mot[k] <= 1'b0;
        tick(3);
    endtask
    task ack;
        ctl[psi_pkg::ACK_BIT] <= 1'b1;
        tick(4);
        ctl[psi_pkg::ACK_BIT] <= 1'b0;
        tick(1);
    endtask
    task finish_test;
        if (num_errors == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task t_reset;
        logic [7:0] ad [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h20, 8'h24, 8'h14};
        logic [31:0] ex [8] = '{32'h1, 32'ha, 32'h64, 32'h4e20, 32'h50, 32'h7fffffff,
            32'h80000001, 32'h0100};
        chk("status", 32'h0100, {16'h0, in_img.status});
        chk("img_len", 32'h10, {27'h0, img_len});
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, ad[i], 32'h0);
            chk("reg", ex[i], q);
        end
        apb(1'b1, psi_pkg::A_STATUS, 32'hffffffff);
        apb(1'b0, psi_pkg::A_STATUS, 32'h0);
        chk("status ro", 32'h0100, q);
        apb(1'b0, 8'h30, 32'h0);
        chk("unmapped", 32'h1, {31'h0, e});
    endtask
    task t_images;
        tgt <= 32'h12345678;
        param <= 64'h89abcdef_0022_0011;
        mot.speed <= 16'h0123;
        mot.actual_pos <= 32'h00000456;
        apb(1'b1, psi_pkg::A_REPLY_ID, 32'h00440033);
        apb(1'b1, psi_pkg::A_REPLY_VAL, 32'h5555aaaa);
        tick(4);
        chk("cmd target", 32'h12345678, cmd.target);
        chk("cmd value", 32'h89abcdef, cmd.param_value);
        chk("cmd id", {16'h0022, 16'h0011}, {cmd.param_index, cmd.param_identifier});
        chk("speed", 32'h0123, {16'h0, in_img.actual_speed});
        chk("pos", 32'h0456, in_img.actual_pos);
        chk("reply id", 32'h00440033, {in_img.param_index, in_img.param_identifier});
        chk("reply val", 32'h5555aaaa, in_img.param_value);
        apb(1'b1, psi_pkg::A_CTRL, 32'h0);
        tick(4);
        chk("short len", 32'h08, {27'h0, img_len});
        chk("short cmd", 32'h0, cmd.param_value);
        chk("short reply", 32'h0, in_img.param_value);
        apb(1'b1, psi_pkg::A_CTRL, 32'h1);
    endtask
    task t_sensors;
        logic [15:0] sv [4] = '{16'd20000, 16'd20001, 16'd29999, 16'd30000};
        logic [15:0] tv [3] = '{16'd81, 16'd76, 16'd75};
        key_rev <= 1'b1;
        tick(4);
        sb(psi_pkg::S_KEY_REV, 1'b1);
        sb(psi_pkg::S_KEY_FWD, 1'b0);
        key_rev <= 1'b0;
        key_fwd <= 1'b1;
        tick(4);
        sb(psi_pkg::S_KEY_REV, 1'b0);
        sb(psi_pkg::S_KEY_FWD, 1'b1);
        key_fwd <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            supply_mv <= sv[i];
            tick(4);
            sb(psi_pkg::S_POWER, i == 1 || i == 2);
        end
        for (int i = 0; i < 3; i++) begin
            temp_c <= tv[i];
            tick(4);
            sb(psi_pkg::S_OVERTEMP, i < 2);
        end
    endtask
    task t_run;
        supply_mv <= 16'd25000;
        tgt <= 32'd100;
        tick(2);
        pulse(EV_TOP - 4);
        pulse(EV_TOP);
        sb(psi_pkg::S_NO_POWER, 1'b0);
        mot.running <= 1'b1;
        mot.follow_err <= 32'd101;
        tick(4);
        sb(psi_pkg::S_RUNNING, 1'b1);
        sb(psi_pkg::S_DRAG, 1'b1);
        mot.running <= 1'b0;
        mot.actual_pos <= 32'd100;
        pulse(EV_TOP - 5);
        sb(psi_pkg::S_RUNNING, 1'b0);
        sb(psi_pkg::S_REACHED, 1'b1);
        sb(psi_pkg::S_LOOP, 1'b0);
        ack();
        sb(psi_pkg::S_DRAG, 1'b0);
        mot.actual_pos <= 32'd200;
        tick(4);
        sb(psi_pkg::S_DISPLACED, 1'b1);
        sb(psi_pkg::S_REACHED, 1'b0);
        apb(1'b1, psi_pkg::A_CTRL, 32'h3);
        mot.actual_pos <= 32'd110;
        tick(4);
        sb(psi_pkg::S_REACHED, 1'b1);
        tgt <= 32'd500;
        tick(2);
        pulse(EV_TOP - 4);
        sb(psi_pkg::S_REACHED, 1'b0);
        supply_mv <= 16'd10000;
        mot.loop_len_zero <= 1'b1;
        pulse(EV_TOP);
        sb(psi_pkg::S_NO_POWER, 1'b1);
        sb(psi_pkg::S_LOOP, 1'b1);
        sb(psi_pkg::S_DISPLACED, 1'b0);
    endtask
    task t_faults;
        pulse(EV_TOP - 9);
        pulse(EV_TOP - 11);
        sb(psi_pkg::S_ABORT, 1'b1);
        sb(psi_pkg::S_BLOCK, 1'b1);
        ack();
        sb(psi_pkg::S_ABORT, 1'b0);
        sb(psi_pkg::S_BLOCK, 1'b0);
        sb(psi_pkg::S_NO_POWER, 1'b0);
        apb(1'b1, psi_pkg::A_LIM_MAX, 32'd1000);
        tgt <= 32'd2000;
        tick(2);
        pulse(EV_TOP - 4);
        sb(psi_pkg::S_BAD_TARGET, 1'b1);
        pulse(EV_TOP);
        sb(psi_pkg::S_BAD_TARGET, 1'b0);
        pulse(EV_TOP - 12);
        sb(psi_pkg::S_FATAL, 1'b1);
        chk("permit", 32'h0, {31'h0, run_permit});
        ack();
        sb(psi_pkg::S_FATAL, 1'b1);
        mot.actual_pos <= 32'd2000;
        tick(4);
        sb(psi_pkg::S_LIM_POS, 1'b1);
        sb(psi_pkg::S_LIM_NEG, 1'b0);
        presetn <= 1'b0;
        tick(2);
        presetn <= 1'b1;
        tick(2);
        chk("permit", 32'h1, {31'h0, run_permit});
        sb(psi_pkg::S_FATAL, 1'b0);
    endtask
    // ----------------------------------------------------------------
    // sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        tick(12);
        presetn <= 1'b1;
        tick(3);
        t_reset();
        t_images();
        t_sensors();
        t_run();
        t_faults();
        finish_test();
    end
    initial begin
        tick(20000);
        num_errors++;
        finish_test();
    end
endmodule // psi_core_tb
